// ===== ee_pkg.sv
// constants, states and timing shared by both ends of the serial eeprom read link
// assumes a 200 MHz core clock on the master end and an oversampling link clock on the device
package ee_pkg;

  // control byte layout
  localparam logic [3:0] CTRL_CODE = 4'hA;
  localparam logic [2:0] BLK_DONT_CARE = 3'h0;
  localparam logic DIR_RD = 1'b1;
  localparam logic DIR_WR = 1'b0;
  localparam int CODE_MSB = 7;
  localparam int CODE_LSB = 4;
  localparam int DIR_BIT = 0;

  // array and byte shape
  localparam int ADDR_W = 8;
  localparam int DATA_W = 8;
  localparam int MEM_WORDS = 256;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [7:0] PTR_RST = 8'h00;

  // master bit timing
  localparam int CORE_PERIOD_NS = 5;
  localparam int LINK_BIT_NS = 160;
  localparam int QTR_CYC = (LINK_BIT_NS / 4 + CORE_PERIOD_NS - 1) / CORE_PERIOD_NS;
  localparam int RX_DEPTH = 2;

  typedef enum logic [2:0] {
    EE_D_IDLE = 3'h0,
    EE_D_RXB = 3'h1,
    EE_D_ACK = 3'h2,
    EE_D_TXB = 3'h3,
    EE_D_RACK = 3'h4
  } ee_dev_st_e;

  typedef enum logic [1:0] {
    EE_P_CTRL = 2'h0,
    EE_P_ADDR = 2'h1,
    EE_P_WDATA = 2'h2
  } ee_dphase_e;

  typedef enum logic [2:0] {
    EE_M_IDLE = 3'h0,
    EE_M_START = 3'h1,
    EE_M_TXB = 3'h2,
    EE_M_RXB = 3'h3,
    EE_M_STOP = 3'h4
  } ee_mst_st_e;

  typedef enum logic [1:0] {
    EE_S_CW = 2'h0,
    EE_S_AD = 2'h1,
    EE_S_CR = 2'h2
  } ee_stage_e;

endpackage

// ===== ee_link_if.sv
// two-wire link between the bus master end and the eeprom device end
// assumes both ends drive the data line open-drain; the wire level is resolved here
`timescale 1ns/1ps
`default_nettype none

interface ee_link_if;
  logic scl;
  logic m_sda_o;
  logic m_sda_oe_n;
  logic d_sda_o;
  logic d_sda_oe_n;
  logic sda;

  // wired-and with pull-up
  assign sda = ~((~m_sda_oe_n & ~m_sda_o) | (~d_sda_oe_n & ~d_sda_o));

  modport master(output scl, output m_sda_o, output m_sda_oe_n, input sda);
  modport device(input scl, input sda, output d_sda_o, output d_sda_oe_n);
endinterface

`default_nettype wire

// ===== ee_buf.sv
// small shift-register buffer with valid and ready on both sides
// assumes a single clock; head entry and flags come straight from flops
`timescale 1ns/1ps
`default_nettype none

module ee_buf #(
  parameter int W = 8,
  parameter int DEPTH = 2
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // fill side
  input wire logic in_valid_i,
  input wire logic [W-1:0] in_data_i,
  output logic in_ready_o,
  // drain side
  output logic out_valid_o,
  output logic [W-1:0] out_data_o,
  input wire logic out_ready_i
);
  localparam int CW = $clog2(DEPTH + 1);

  if (DEPTH < 2 || W < 1) begin : g_chk
    $error("ee_buf needs DEPTH >= 2 and W >= 1");
  end

  typedef struct packed {
    logic [DEPTH-1:0][W-1:0] d;
    logic [CW-1:0] cnt;
    logic rdy;
    logic vld;
  } ee_buf_s;

  ee_buf_s r;
  ee_buf_s n;
  logic pop;
  logic push;

  always_comb begin
    n = r;
    pop = r.vld && out_ready_i;
    push = in_valid_i && r.rdy;
    if (pop) begin
      for (int i = 0; i < DEPTH - 1; i++) begin
        n.d[i] = r.d[i+1];
      end
      n.cnt = r.cnt - CW'(1);
    end
    if (push) begin
      n.d[n.cnt] = in_data_i;
      n.cnt = n.cnt + CW'(1);
    end
    n.rdy = (n.cnt != CW'(DEPTH));
    n.vld = (n.cnt != CW'(0));
  end

  always_ff @(posedge clk_i) begin
    if (!rst_n_i) begin
      r <= '0;
      r.rdy <= 1'b1;
    end else begin
      r <= n;
    end
  end

  assign in_ready_o = r.rdy;
  assign out_valid_o = r.vld;
  assign out_data_o = r.d[0];
endmodule

`default_nettype wire

// ===== ee_master.sv
// bus master end: issues current-address, random and sequential reads
// assumes the device end on the far side of ee_link_if; makes the link clock by a divider
`timescale 1ns/1ps
`default_nettype none

module ee_master #(
  parameter int QTR = ee_pkg::QTR_CYC
) (
  // clock and reset
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  // read command
  input wire logic cmd_valid_i,
  input wire logic cmd_random_i,
  input wire logic [7:0] cmd_addr_i,
  input wire logic [7:0] cmd_count_i,
  output logic cmd_ready_o,
  // read data stream
  output logic rd_valid_o,
  output logic [7:0] rd_data_o,
  input wire logic rd_ready_i,
  // status
  output logic done_o,
  output logic nack_o,
  // link
  ee_link_if.master bus
);
  if (QTR < 4 || QTR > 256) begin : g_chk
    $error("ee_master needs 4 <= QTR <= 256");
  end

  typedef struct packed {
    ee_pkg::ee_mst_st_e st;
    ee_pkg::ee_stage_e stage;
    logic [1:0] ph;
    logic [7:0] qcnt;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [7:0] addr;
    logic [7:0] cnt;
    logic ackb;
    logic sd1;
    logic sd2;
    logic scl;
    logic sda_lo;
    logic sda_oe_n;
    logic rdy;
    logic done;
    logic nack;
    logic push;
    logic [7:0] rxd;
  } ee_mst_s;

  ee_mst_s r;
  ee_mst_s n;
  logic adv;
  logic hold;
  logic buf_rdy;

  always_comb begin
    n = r;
    n.done = 1'b0;
    n.nack = 1'b0;
    n.push = 1'b0;
    n.sd1 = bus.sda;
    n.sd2 = r.sd1;
    // stall before a byte while the data buffer is full
    hold = (r.st == ee_pkg::EE_M_RXB) && (r.ph == 2'h0) && (r.bitc == 4'h0) && !buf_rdy;
    adv = (r.qcnt == 8'(QTR - 1));
    if (r.st != ee_pkg::EE_M_IDLE && !hold) begin
      n.qcnt = adv ? 8'h00 : r.qcnt + 8'h01;
    end
    unique case (r.st)
      ee_pkg::EE_M_IDLE: begin
        if (cmd_valid_i && r.rdy) begin
          n.addr = cmd_addr_i;
          n.cnt = cmd_count_i;
          n.st = ee_pkg::EE_M_START;
          n.ph = 2'h0;
          n.qcnt = 8'h00;
          if (cmd_random_i) begin
            n.stage = ee_pkg::EE_S_CW;
            n.sh = {ee_pkg::CTRL_CODE, ee_pkg::BLK_DONT_CARE, ee_pkg::DIR_WR}; // [R6]
          end else begin
            n.stage = ee_pkg::EE_S_CR;
            n.sh = {ee_pkg::CTRL_CODE, ee_pkg::BLK_DONT_CARE, ee_pkg::DIR_RD}; // [R1]
          end
        end
      end
      ee_pkg::EE_M_START: begin
        if (adv) begin
          n.ph = r.ph + 2'h1;
          unique case (r.ph)
            2'h0: n.sda_oe_n = 1'b1;
            2'h1: n.scl = 1'b1;
            2'h2: n.sda_oe_n = 1'b0;
            2'h3: begin
              n.scl = 1'b0;
              n.st = ee_pkg::EE_M_TXB;
              n.bitc = 4'h0;
            end
          endcase
        end
      end
      ee_pkg::EE_M_TXB, ee_pkg::EE_M_RXB: begin
        if (adv) begin
          n.ph = r.ph + 2'h1;
          unique case (r.ph)
            2'h0: begin
              if (r.bitc < ee_pkg::BYTE_BITS) begin
                n.sda_oe_n = (r.st == ee_pkg::EE_M_TXB) ? r.sh[7] : 1'b1;
              end else begin
                // ack while more bytes are wanted, leave high on the last
                n.sda_oe_n = (r.st == ee_pkg::EE_M_TXB) || (r.cnt == 8'h00); // [R5] [R10]
              end
            end
            2'h1: n.scl = 1'b1;
            2'h2: begin
              if (r.bitc < ee_pkg::BYTE_BITS) begin
                n.sh = {r.sh[6:0], r.sd2};
              end else begin
                n.ackb = r.sd2;
              end
            end
            2'h3: begin
              n.scl = 1'b0;
              if (r.bitc < ee_pkg::BYTE_BITS) begin
                n.bitc = r.bitc + 4'h1;
              end else begin
                n.bitc = 4'h0;
                if (r.st == ee_pkg::EE_M_RXB) begin
                  n.push = 1'b1;
                  n.rxd = r.sh;
                  if (r.cnt == 8'h00) begin
                    n.st = ee_pkg::EE_M_STOP; // [R5]
                  end else begin
                    n.cnt = r.cnt - 8'h01;
                  end
                end else if (r.ackb) begin
                  n.nack = 1'b1;
                  n.st = ee_pkg::EE_M_STOP;
                end else begin
                  unique case (r.stage)
                    ee_pkg::EE_S_CW: begin
                      n.sh = r.addr; // [R6]
                      n.stage = ee_pkg::EE_S_AD;
                    end
                    ee_pkg::EE_S_AD: begin
                      n.sh = {ee_pkg::CTRL_CODE, ee_pkg::BLK_DONT_CARE, ee_pkg::DIR_RD}; // [R9]
                      n.stage = ee_pkg::EE_S_CR;
                      n.st = ee_pkg::EE_M_START; // [R7]
                    end
                    default: n.st = ee_pkg::EE_M_RXB;
                  endcase
                end
              end
            end
          endcase
        end
      end
      ee_pkg::EE_M_STOP: begin
        if (adv) begin
          n.ph = r.ph + 2'h1;
          unique case (r.ph)
            2'h0: n.sda_oe_n = 1'b0;
            2'h1: n.scl = 1'b1;
            2'h2: n.sda_oe_n = 1'b1;
            2'h3: begin
              n.st = ee_pkg::EE_M_IDLE;
              n.done = 1'b1;
            end
          endcase
        end
      end
      default: n.st = ee_pkg::EE_M_IDLE;
    endcase
    n.rdy = (n.st == ee_pkg::EE_M_IDLE);
  end

  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      r <= '0;
      r.scl <= 1'b1;
      r.sda_oe_n <= 1'b1;
      r.rdy <= 1'b1;
      // data synchroniser starts at the idle bus level
      r.sd1 <= 1'b1;
      r.sd2 <= 1'b1;
    end else begin
      r <= n;
    end
  end

  ee_buf #(.W(8), .DEPTH(ee_pkg::RX_DEPTH)) u_rxbuf (
    .clk_i(core_clk_i),
    .rst_n_i(rst_n_i),
    .in_valid_i(r.push),
    .in_data_i(r.rxd),
    .in_ready_o(buf_rdy),
    .out_valid_o(rd_valid_o),
    .out_data_o(rd_data_o),
    .out_ready_i(rd_ready_i)
  );

  assign cmd_ready_o = r.rdy;
  assign done_o = r.done;
  assign nack_o = r.nack;
  assign bus.scl = r.scl;
  assign bus.m_sda_o = r.sda_lo;
  assign bus.m_sda_oe_n = r.sda_oe_n;
endmodule

`default_nettype wire

// ===== ee_device.sv
// eeprom device end: read path of a two-wire serial eeprom slave
// assumes a free-running link clock that oversamples the bus; bus and status pins are async
//
// Overview of operation
// (R1) reads start like writes, direction bit one
// (R2) current, random and sequential reads supported
// (R3) pointer holds last accessed location plus one
// (R4) ack matching read control, send pointer byte
// (R5) master nacks and stops; device stops driving
// (R6) random read first sends write control, address
// (R7) after address ack master sends repeated start
// (R8) repeated start aborts write, pointer still loaded
// (R9) resent read control acked, byte at address
// (R10) each master ack gets next consecutive byte
// (R11) pointer increments after every byte access
// (R12) one sequential read can return whole array
// (R13) low supply holds erase/write logic disabled
// (R14) only control code 1010 answered, block ignored
// (R15) nothing acknowledged during programming cycle
// (R16) on master nack release data line high
// (R17) pointer wraps from top back to zero
`timescale 1ns/1ps
`default_nettype none

module ee_device #(
  parameter int WORDS = ee_pkg::MEM_WORDS
) (
  // link clock and reset
  input wire logic link_clk_i,
  input wire logic link_rst_n_i,
  // array preload, link clock domain
  input wire logic fill_we_i,
  input wire logic [7:0] fill_addr_i,
  input wire logic [7:0] fill_data_i,
  // async status from the analogue side
  input wire logic prog_busy_i,
  input wire logic low_vcc_i,
  // observed state
  output logic ew_enable_o,
  output logic [7:0] ptr_o,
  // link
  ee_link_if.device bus
);
  if (WORDS != (1 << ee_pkg::ADDR_W)) begin : g_chk
    $error("ee_device needs WORDS equal to two to the address width");
  end

  typedef struct packed {
    ee_pkg::ee_dev_st_e st;
    ee_pkg::ee_dphase_e ph;
    logic rd;
    logic [3:0] bitc;
    logic [7:0] sh;
    logic [7:0] ptr;
    logic mack;
    logic scl1;
    logic scl2;
    logic scl3;
    logic sda1;
    logic sda2;
    logic sda3;
    logic bsy1;
    logic bsy2;
    logic lv1;
    logic lv2;
    logic sda_lo;
    logic sda_oe_n;
    logic ew_en;
  } ee_dev_s;

  ee_dev_s r;
  ee_dev_s n;
  logic [7:0] mem [WORDS];
  logic start_c;
  logic stop_c;
  logic rise;
  logic fall;
  logic match;

  always_comb begin
    n = r;
    // two-flop synchronisers, third flop only for edge detection
    n.scl1 = bus.scl;
    n.scl2 = r.scl1;
    n.scl3 = r.scl2;
    n.sda1 = bus.sda;
    n.sda2 = r.sda1;
    n.sda3 = r.sda2;
    n.bsy1 = prog_busy_i;
    n.bsy2 = r.bsy1;
    n.lv1 = low_vcc_i;
    n.lv2 = r.lv1;
    n.ew_en = !r.lv2; // [R13]
    start_c = r.scl2 && r.scl3 && r.sda3 && !r.sda2;
    stop_c = r.scl2 && r.scl3 && !r.sda3 && r.sda2;
    rise = r.scl2 && !r.scl3;
    fall = !r.scl2 && r.scl3;
    match = (r.sh[ee_pkg::CODE_MSB:ee_pkg::CODE_LSB] == ee_pkg::CTRL_CODE); // [R14]
    if (start_c) begin
      // a repeated start drops any write in progress; pointer is kept
      n.st = ee_pkg::EE_D_RXB; // [R8]
      n.ph = ee_pkg::EE_P_CTRL;
      n.bitc = 4'h0;
      n.sda_oe_n = 1'b1;
    end else if (stop_c) begin
      n.st = ee_pkg::EE_D_IDLE; // [R5]
      n.sda_oe_n = 1'b1;
    end else begin
      unique case (r.st)
        ee_pkg::EE_D_IDLE: n.sda_oe_n = 1'b1;
        ee_pkg::EE_D_RXB: begin
          if (rise) begin
            n.sh = {r.sh[6:0], r.sda2};
            n.bitc = r.bitc + 4'h1;
          end else if (fall && r.bitc == ee_pkg::BYTE_BITS) begin
            unique case (r.ph)
              ee_pkg::EE_P_CTRL: begin
                if (match && !r.bsy2) begin
                  n.rd = r.sh[ee_pkg::DIR_BIT]; // [R1] [R14]
                  n.st = ee_pkg::EE_D_ACK; // [R4] [R9]
                  n.sda_oe_n = 1'b0;
                end else begin
                  n.st = ee_pkg::EE_D_IDLE; // [R14] [R15]
                end
              end
              ee_pkg::EE_P_ADDR: begin
                n.ptr = r.sh; // [R8]
                n.st = ee_pkg::EE_D_ACK;
                n.sda_oe_n = 1'b0;
              end
              ee_pkg::EE_P_WDATA: begin
                // data byte is acked but not stored anywhere; the access still moves the pointer
                n.ptr = r.ptr + 8'h01; // [R11]
                n.st = ee_pkg::EE_D_ACK;
                n.sda_oe_n = 1'b0;
              end
              default: n.st = ee_pkg::EE_D_IDLE;
            endcase
          end
        end
        ee_pkg::EE_D_ACK: begin
          if (fall) begin
            n.bitc = 4'h0;
            if (r.rd) begin
              // current or random read: send byte at pointer, then advance
              n.sh = mem[r.ptr]; // [R2] [R3] [R4]
              n.ptr = r.ptr + 8'h01; // [R3] [R11] [R17]
              n.sda_oe_n = mem[r.ptr][7];
              n.st = ee_pkg::EE_D_TXB;
            end else begin
              n.sda_oe_n = 1'b1;
              n.st = ee_pkg::EE_D_RXB;
              n.ph = (r.ph == ee_pkg::EE_P_CTRL) ? ee_pkg::EE_P_ADDR : ee_pkg::EE_P_WDATA;
            end
          end
        end
        ee_pkg::EE_D_TXB: begin
          if (fall) begin
            if (r.bitc == ee_pkg::BYTE_BITS - 4'h1) begin
              n.sda_oe_n = 1'b1;
              n.st = ee_pkg::EE_D_RACK;
            end else begin
              n.sh = {r.sh[6:0], 1'b0};
              n.sda_oe_n = r.sh[6];
              n.bitc = r.bitc + 4'h1;
            end
          end
        end
        ee_pkg::EE_D_RACK: begin
          if (rise) begin
            n.mack = !r.sda2;
          end else if (fall) begin
            n.bitc = 4'h0;
            if (r.mack) begin
              // sequential read continues without limit, wrapping the pointer
              n.sh = mem[r.ptr]; // [R10] [R12]
              n.ptr = r.ptr + 8'h01; // [R11] [R17]
              n.sda_oe_n = mem[r.ptr][7];
              n.st = ee_pkg::EE_D_TXB;
            end else begin
              n.sda_oe_n = 1'b1; // [R16]
              n.st = ee_pkg::EE_D_IDLE; // [R5]
            end
          end
        end
        default: begin
          n.st = ee_pkg::EE_D_IDLE;
          n.sda_oe_n = 1'b1;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_i) begin
    if (!link_rst_n_i) begin
      r <= '0;
      r.ptr <= ee_pkg::PTR_RST;
      r.sda_oe_n <= 1'b1;
      // synchronisers start at the idle bus level, so no false edge follows reset
      r.scl1 <= 1'b1;
      r.scl2 <= 1'b1;
      r.scl3 <= 1'b1;
      r.sda1 <= 1'b1;
      r.sda2 <= 1'b1;
      r.sda3 <= 1'b1;
    end else begin
      r <= n;
    end
  end

  // preload port for the array contents
  always_ff @(posedge link_clk_i) begin
    if (fill_we_i) begin
      mem[fill_addr_i] <= fill_data_i;
    end
  end

  assign ew_enable_o = r.ew_en;
  assign ptr_o = r.ptr;
  assign bus.d_sda_o = r.sda_lo;
  assign bus.d_sda_oe_n = r.sda_oe_n;
endmodule

`default_nettype wire

// ===== ee_link_assertions.sv
// checker for the two-wire link between the master end and the device end
// assumes instantiation beside ee_link_if with both clocks and resets
`timescale 1ns/1ps
`default_nettype none

module ee_link_assertions (
  // clocks and resets
  input wire logic core_clk_i,
  input wire logic rst_n_i,
  input wire logic link_clk_i,
  input wire logic link_rst_n_i,
  // link signals
  input wire logic scl,
  input wire logic m_sda_o,
  input wire logic m_sda_oe_n,
  input wire logic d_sda_o,
  input wire logic d_sda_oe_n,
  input wire logic sda
);
  logic [3:0] bit_cnt_r;
  logic [7:0] shf_r;
  logic first_r;
  logic rd_r;

  // bit tracker on scl rises, cleared by start
  always_ff @(posedge core_clk_i) begin
    if (!rst_n_i) begin
      bit_cnt_r <= 4'h0;
      shf_r <= 8'h00;
      first_r <= 1'b0;
      rd_r <= 1'b0;
    end else if (scl && $fell(sda)) begin
      bit_cnt_r <= 4'h0;
      first_r <= 1'b1;
      rd_r <= 1'b0;
    end else if ($rose(scl)) begin
      if (bit_cnt_r < 4'h8) begin
        shf_r <= {shf_r[6:0], sda};
        bit_cnt_r <= bit_cnt_r + 4'h1;
      end else begin
        bit_cnt_r <= 4'h0;
        first_r <= 1'b0;
        if (first_r) rd_r <= shf_r[0] & ~sda;
      end
    end
  end

  a_mst_bits_owned: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(scl) && bit_cnt_r < 4'h8 && (first_r || !rd_r) |-> d_sda_oe_n)
    else $error("device drove a master bit");
  a_mst_ack_owned: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(scl) && rd_r && !first_r && bit_cnt_r == 4'h8 |-> d_sda_oe_n)
    else $error("device drove the master ack");
  a_nack_release: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i)
    $rose(scl) && rd_r && !first_r && bit_cnt_r == 4'h8 && sda |=> d_sda_oe_n [*8])
    else $error("device drove after nack");
  a_mst_open_drain: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i) !m_sda_oe_n |-> !m_sda_o)
    else $error("master drove data high");
  a_stop_scl_idle: assert property (
    @(posedge core_clk_i) disable iff (!rst_n_i) scl && $rose(sda) |=> scl [*8])
    else $error("clock moved after stop");
  a_stop_release: assert property (
    @(posedge link_clk_i) disable iff (!link_rst_n_i)
    scl && $rose(sda) |=> d_sda_oe_n [*8])
    else $error("device drove after stop");
  a_dev_change_low: assert property (
    @(posedge link_clk_i) disable iff (!link_rst_n_i) $changed(d_sda_oe_n) |-> !scl)
    else $error("device changed data while clock high");
  a_dev_open_drain: assert property (
    @(posedge link_clk_i) disable iff (!link_rst_n_i) !d_sda_oe_n |-> !d_sda_o)
    else $error("device drove data high");
  a_dev_bit_stands: assert property (
    @(posedge link_clk_i) disable iff (!link_rst_n_i)
    $fell(d_sda_oe_n) |-> !d_sda_oe_n [*6])
    else $error("device bit too short");
endmodule

`default_nettype wire

// ===== test_serial_eeprom_read_path.sv
// testbench joining master and device ends over the two-wire link
// assumes ee_pkg, ee_link_if, ee_buf, ee_master, ee_device compiled before
`timescale 1ns/1ps
`default_nettype none

module test_serial_eeprom_read_path;
  logic core_clk_i, rst_n_i, link_clk_i, link_rst_n_i, cmd_valid_i, cmd_random_i;
  logic rd_ready_i, fill_we_i, prog_busy_i, low_vcc_i;
  logic cmd_ready_o, rd_valid_o, done_o, nack_o, ew_enable_o;
  logic [7:0] cmd_addr_i, cmd_count_i, fill_addr_i, fill_data_i, rd_data_o, ptr_o;
  int n_mismatch, checked;

  ee_link_if u_ee_link_if ();
  ee_master #(.QTR(6)) u_ee_master (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .cmd_valid_i(cmd_valid_i), .cmd_random_i(cmd_random_i), .cmd_addr_i(cmd_addr_i),
    .cmd_count_i(cmd_count_i), .cmd_ready_o(cmd_ready_o), .rd_valid_o(rd_valid_o),
    .rd_data_o(rd_data_o), .rd_ready_i(rd_ready_i), .done_o(done_o), .nack_o(nack_o),
    .bus(u_ee_link_if));
  ee_device u_ee_device (.link_clk_i(link_clk_i), .link_rst_n_i(link_rst_n_i),
    .fill_we_i(fill_we_i), .fill_addr_i(fill_addr_i), .fill_data_i(fill_data_i),
    .prog_busy_i(prog_busy_i), .low_vcc_i(low_vcc_i), .ew_enable_o(ew_enable_o),
    .ptr_o(ptr_o), .bus(u_ee_link_if));
  ee_link_assertions u_ee_link_assertions (.core_clk_i(core_clk_i), .rst_n_i(rst_n_i),
    .link_clk_i(link_clk_i), .link_rst_n_i(link_rst_n_i), .scl(u_ee_link_if.scl),
    .m_sda_o(u_ee_link_if.m_sda_o), .m_sda_oe_n(u_ee_link_if.m_sda_oe_n),
    .d_sda_o(u_ee_link_if.d_sda_o), .d_sda_oe_n(u_ee_link_if.d_sda_oe_n),
    .sda(u_ee_link_if.sda));

  initial begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #3.7;
    forever #7.5 link_clk_i = ~link_clk_i;
  end

  function automatic logic [7:0] pat(input logic [7:0] a);
    return {a[3:0], a[7:4]} ^ 8'h3C;
  endfunction

  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t flag %b expected %b", $time, got, exp);
    end
  endtask

  task automatic chkv(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t value %h expected %h", $time, got, exp);
    end
  endtask

  task automatic report_and_stop;
    $display("checked %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // one command, then collect bytes until done and the buffer is empty
  task automatic run_read(input logic rnd, input logic [7:0] addr, input int cnt,
                          input int stall, input logic en);
    int n;
    logic [7:0] a;
    logic gd;
    logic gn;
    n = 0;
    a = addr;
    gd = 1'b0;
    gn = 1'b0;
    @(posedge core_clk_i);
    cmd_valid_i <= 1'b1;
    cmd_random_i <= rnd;
    cmd_addr_i <= addr;
    cmd_count_i <= cnt[7:0];
    rd_ready_i <= (stall == 0);
    @(negedge core_clk_i);
    chk1(cmd_ready_o, 1'b1);
    @(posedge core_clk_i);
    cmd_valid_i <= 1'b0;
    for (int k = 0; k < 70000 && !(gd && rd_valid_o !== 1'b1); k++) begin
      @(posedge core_clk_i);
      if (k == stall) rd_ready_i <= 1'b1;
      @(negedge core_clk_i);
      if (rd_valid_o === 1'b1 && rd_ready_i === 1'b1) begin
        chkv({8'h00, rd_data_o}, {8'h00, pat(a)});
        a = a + 8'h01;
        n++;
      end
      if (nack_o === 1'b1) gn = 1'b1;
      if (done_o === 1'b1) gd = 1'b1;
    end
    chk1(gd, 1'b1);
    chk1(gn, en);
    chkv(n[15:0], en ? 16'h0000 : cnt[15:0] + 16'h0001);
  endtask

  task automatic preload;
    for (int i = 0; i < 256; i++) begin
      @(posedge link_clk_i);
      fill_we_i <= 1'b1;
      fill_addr_i <= i[7:0];
      fill_data_i <= pat(i[7:0]);
    end
    @(posedge link_clk_i);
    fill_we_i <= 1'b0;
  endtask

  task automatic s_supply;
    for (int i = 0; i < 2; i++) begin
      @(posedge link_clk_i);
      low_vcc_i <= ~i[0];
      repeat (5) @(posedge link_clk_i);
      @(negedge link_clk_i);
      chk1(ew_enable_o, i[0]);
    end
  endtask

  task automatic s_random;
    run_read(1'b1, 8'h5C, 0, 0, 1'b0);
    chkv({8'h00, ptr_o}, 16'h005D);
  endtask

  task automatic s_stall_seq;
    run_read(1'b0, 8'h5D, 3, 1500, 1'b0);
    chkv({8'h00, ptr_o}, 16'h0061);
  endtask

  task automatic s_busy;
    @(posedge link_clk_i);
    prog_busy_i <= 1'b1;
    repeat (3) @(posedge link_clk_i);
    run_read(1'b0, 8'h61, 0, 0, 1'b1);
    chkv({8'h00, ptr_o}, 16'h0061);
    @(posedge link_clk_i);
    prog_busy_i <= 1'b0;
    repeat (3) @(posedge link_clk_i);
  endtask

  task automatic s_full_array;
    run_read(1'b1, 8'h00, 255, 0, 1'b0);
    chkv({8'h00, ptr_o}, 16'h0000);
    run_read(1'b0, 8'h00, 0, 0, 1'b0);
    chkv({8'h00, ptr_o}, 16'h0001);
  endtask

  initial begin
    n_mismatch = 0;
    checked = 0;
    rst_n_i = 1'b0;
    link_rst_n_i = 1'b0;
    cmd_valid_i = 1'b0;
    cmd_random_i = 1'b0;
    cmd_addr_i = 8'h00;
    cmd_count_i = 8'h00;
    rd_ready_i = 1'b1;
    fill_we_i = 1'b0;
    fill_addr_i = 8'h00;
    fill_data_i = 8'h00;
    prog_busy_i = 1'b0;
    low_vcc_i = 1'b0;
    repeat (20) @(posedge core_clk_i);
    rst_n_i <= 1'b1;
    @(posedge link_clk_i);
    link_rst_n_i <= 1'b1;
    preload();
    s_supply();
    s_random();
    s_stall_seq();
    s_busy();
    s_full_array();
    report_and_stop();
  end

  // cuts a hang short
  initial begin
    #450000;
    n_mismatch++;
    $display("[FAIL] %0t watchdog expired", $time);
    report_and_stop();
  end
endmodule

`default_nettype wire
